// [design/ghp_regs.svh]
// Constants of the graphics host port
`ifndef GHP_REGS_SVH
`define GHP_REGS_SVH
// Contract
// - Reset stops video and refresh, selects 16-bit bus, leaves program mode, empties FIFOs.
// - Writing internal register 27 resets likewise but leaves video timing untouched.
// - Port select and strobes decode into four write and four read functions.
// - Instruction write into a full queue is silently dropped.
// - Instruction words queue in write order and leave in that order.
// - Status bit 14 and its pin are high while the instruction queue has room.
// - Only a reset can flush the instruction queue.
// - Status reads never disturb the engine or its state.
// - Block input write into a full queue is silently dropped.
// - During block input, bit 15 and pin high only with room for two words.
// - Block output read returns next of four words; empty gives undefined data.
// - During block output, bit 15 and pin high only with two words waiting.
// - Index write selects the internal register and does nothing else.
// - Index read returns the last index written, without side effect.
// - Data write stores into the register the index selects.
// - Data read returns readable register contents, else undefined data.
// - Status bit 0 is high when any enabled request is latched.
// - Status bits 1 to 9 show the nine latched requests in order.
// - Status bit 10 shows the live idle state.
// - Bit 11 mirrors the sync reset pin, 14 and 15 the flow pins, 12 undefined.
// - Bit 13 sets on a pick hit while picking, clears on acknowledge bit 9.
// - Acknowledge clears a request only when its condition is gone.
// - In 8-bit mode each register access takes two byte transfers on lines 7-0.
`define GHP_IDX_RESET   6'h1b
`define GHP_IDX_IEN     6'h10
`define GHP_IDX_IACK    6'h11
`define GHP_IDX_CTRL    6'h12
`define GHP_IDX_BUSW    6'h13
`define GHP_IDX_BORD    6'h14
`define GHP_IFIFO_DEPTH 8
`define GHP_BIF_DEPTH   4
`define GHP_BOF_DEPTH   4
`define GHP_XFER_MIN    3'h2
`define GHP_ACK_PICK    9
`define GHP_IEN_RESET   9'h000
`define GHP_CTRL_RESET  4'h0
`endif

// [design/ghp_pkg.sv]
// Types of the graphics host port
package ghp_pkg;
  typedef enum logic [1:0] {
    GHP_SEL_QUEUE = 2'b00,
    GHP_SEL_BLOCK = 2'b01,
    GHP_SEL_INDEX = 2'b10,
    GHP_SEL_DATA  = 2'b11
  } ghp_sel_type;
  typedef struct packed {
    ghp_sel_type sel;
    logic        rd;
    logic        wr;
    logic [15:0] data;
  } ghp_bus_type;
  typedef struct packed {
    logic progMode;
    logic memRefresh;
    logic videoRefresh;
    logic videoTiming;
  } ghp_ctrl_type;
endpackage

// [design/ghp_host_port.sv]
// Host port with register file and three queues
`timescale 1ns/1ns
`include "ghp_regs.svh"
module ghp_fifo #(
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       flush,
  // Fill side
  input  wire logic                       push,
  input  wire logic [15:0]                pushData,
  // Drain side
  input  wire logic                       pop,
  output logic      [15:0]                head,
  output logic      [$clog2(DEPTH):0]     count
);
  localparam int AW = $clog2(DEPTH);
  logic [15:0]   mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0]   count_r;
  logic          doPush;
  logic          doPop;

  // Full queue drops the word; empty queue ignores the pop
  assign doPush = push && (count_r != (AW+1)'(DEPTH));
  assign doPop  = pop && (count_r != '0);
  assign head   = mem[rdPtr_r];
  assign count  = count_r;

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_r] <= pushData;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else if (flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (doPush) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (doPop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      if (doPush && !doPop) begin
        count_r <= count_r + 1'b1;
      end else if (doPop && !doPush) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // ghp_fifo

module ghp_host_port (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // Host pins
  input  wire logic                portSelHi,
  input  wire logic                portSelLo,
  input  wire logic                rdStrobe,
  input  wire logic                wrStrobe,
  input  wire logic [15:0]         hostDataIn,
  output logic      [15:0]         hostDataOut,
  output logic                     hostDataOe,
  // Flow pins
  output logic                     instrRoomFlag,
  output logic                     blockXferRequest,
  // Instruction queue to engine
  input  wire logic                instrPop,
  output logic      [15:0]         instrWord,
  output logic                     instrValid,
  // Block queues
  input  wire logic                blockInActive,
  input  wire logic                blockInPop,
  output logic      [15:0]         blockInWord,
  output logic                     blockInValid,
  input  wire logic                blockOutActive,
  input  wire logic                blockOutPush,
  input  wire logic [15:0]         blockOutData,
  output logic                     blockOutRoom,
  // Engine conditions
  input  wire logic [8:0]          condLevel,
  input  wire logic                pickHit,
  input  wire logic                pickEnable,
  input  wire logic                horizSyncResetPin,
  // Engine controls
  output logic                     regWrStrobe,
  output logic      [5:0]          regWrIndex,
  output logic      [15:0]         regWrData,
  output ghp_pkg::ghp_ctrl_type    ctrl,
  output logic                     coreReset,
  output logic                     byteMode
);
  import ghp_pkg::*;

  ghp_bus_type  busMeta_r;
  ghp_bus_type  bus_r;
  ghp_bus_type  busPrev_r;
  logic         hsMeta_r;
  logic         hs_r;
  logic [15:0]  index_r;
  logic [8:0]   ien_r;
  logic [8:0]   latch_r;
  logic         pick_r;
  logic         byteOrder_r;
  logic         phase_r;
  logic [7:0]   holdByte_r;
  logic [15:0]  regMem [64];
  logic         rdEdge;
  logic         wrEdge;
  logic         regWr;
  logic [15:0]  wrWord;
  logic [5:0]   idx;
  logic [15:0]  regWord;
  logic [15:0]  readWord;
  logic [15:0]  statusWord;
  logic [8:0]   condAll;
  logic [8:0]   ackClr;
  logic         pickAck;
  logic [15:0]  iHead;
  logic [15:0]  biHead;
  logic [15:0]  boHead;
  logic [3:0]   iCount;
  logic [2:0]   biCount;
  logic [2:0]   boCount;

  // Pins cross into the clock domain through two flops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busMeta_r <= '0;
      bus_r     <= '0;
      busPrev_r <= '0;
      hsMeta_r  <= 1'b0;
      hs_r      <= 1'b0;
    end else begin
      busMeta_r <= '{sel: ghp_sel_type'({portSelHi, portSelLo}), rd: rdStrobe,
                     wr: wrStrobe, data: hostDataIn};
      bus_r     <= busMeta_r;
      busPrev_r <= bus_r;
      hsMeta_r  <= horizSyncResetPin;
      hs_r      <= hsMeta_r;
    end
  end

  // One access per strobe, taken at its leading edge
  assign rdEdge = bus_r.rd && !busPrev_r.rd;
  assign wrEdge = bus_r.wr && !busPrev_r.wr;
  assign idx    = index_r[5:0];

  // Narrow bus pairs two bytes into one register word
  assign wrWord = !byteMode ? bus_r.data :
                  byteOrder_r ? {bus_r.data[7:0], holdByte_r} :
                  {holdByte_r, bus_r.data[7:0]};
  assign regWr  = wrEdge && (bus_r.sel == GHP_SEL_DATA) && (!byteMode || phase_r);

  ghp_fifo #(.DEPTH(`GHP_IFIFO_DEPTH)) instrQueue (
    .clk      (clk),
    .reset    (reset),
    .flush    (coreReset),
    .push     (wrEdge && bus_r.sel == GHP_SEL_QUEUE),
    .pushData (bus_r.data),
    .pop      (instrPop),
    .head     (iHead),
    .count    (iCount)
  );

  ghp_fifo #(.DEPTH(`GHP_BIF_DEPTH)) blockInQueue (
    .clk      (clk),
    .reset    (reset),
    .flush    (coreReset),
    .push     (wrEdge && bus_r.sel == GHP_SEL_BLOCK),
    .pushData (bus_r.data),
    .pop      (blockInPop),
    .head     (biHead),
    .count    (biCount)
  );

  ghp_fifo #(.DEPTH(`GHP_BOF_DEPTH)) blockOutQueue (
    .clk      (clk),
    .reset    (reset),
    .flush    (coreReset),
    .push     (blockOutPush),
    .pushData (blockOutData),
    .pop      (rdEdge && bus_r.sel == GHP_SEL_BLOCK),
    .head     (boHead),
    .count    (boCount)
  );

  // Engine side words are registered on each pop
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      instrWord    <= '0;
      instrValid   <= 1'b0;
      blockInWord  <= '0;
      blockInValid <= 1'b0;
      blockOutRoom <= 1'b0;
    end else begin
      instrValid   <= instrPop && iCount != '0 && !coreReset;
      blockInValid <= blockInPop && biCount != '0 && !coreReset;
      blockOutRoom <= boCount != 3'(`GHP_BOF_DEPTH) && !coreReset;
      if (instrPop) begin
        instrWord <= iHead;
      end
      if (blockInPop) begin
        blockInWord <= biHead;
      end
    end
  end

  // Flow pins; bit 15 follows whichever block direction runs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      instrRoomFlag    <= 1'b0;
      blockXferRequest <= 1'b0;
    end else begin
      instrRoomFlag    <= iCount != 4'(`GHP_IFIFO_DEPTH);
      blockXferRequest <= (blockInActive && (3'(`GHP_BIF_DEPTH) - biCount) >= `GHP_XFER_MIN) ||
                          (blockOutActive && boCount >= `GHP_XFER_MIN);
    end
  end

  // Index register; writes have no other effect
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      index_r <= '0;
    end else if (wrEdge && bus_r.sel == GHP_SEL_INDEX) begin
      index_r <= bus_r.data;
    end
  end

  // Byte pairing phase, restarted by either reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_r    <= 1'b0;
      holdByte_r <= '0;
    end else if (coreReset) begin
      phase_r <= 1'b0;
    end else if (byteMode && bus_r.sel == GHP_SEL_DATA && (rdEdge || wrEdge)) begin
      phase_r <= !phase_r;
      if (wrEdge && !phase_r) begin
        holdByte_r <= bus_r.data[7:0];
      end
    end
  end

  // Soft reset pulse from register 27
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      coreReset <= 1'b1;
    end else begin
      coreReset <= regWr && idx == `GHP_IDX_RESET;
    end
  end

  // Mode and control registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl        <= `GHP_CTRL_RESET;
      byteMode    <= 1'b0;
      byteOrder_r <= 1'b0;
      ien_r       <= `GHP_IEN_RESET;
    end else if (coreReset) begin
      ctrl        <= '{videoTiming: ctrl.videoTiming, default: 1'b0};
      byteMode    <= 1'b0;
    end else if (regWr) begin
      unique case (idx)
        `GHP_IDX_CTRL: ctrl        <= ghp_ctrl_type'(wrWord[3:0]);
        `GHP_IDX_BUSW: byteMode    <= 1'b1;
        `GHP_IDX_BORD: byteOrder_r <= wrWord[0];
        `GHP_IDX_IEN:  ien_r       <= wrWord[8:0];
        default: ;
      endcase
    end
  end

  // Plain registers land in a store and go out to the engine
  always_ff @(posedge clk) begin
    if (regWr) begin
      regMem[idx] <= wrWord;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regWrStrobe <= 1'b0;
      regWrIndex  <= '0;
      regWrData   <= '0;
    end else begin
      regWrStrobe <= regWr;
      if (regWr) begin
        regWrIndex <= idx;
        regWrData  <= wrWord;
      end
    end
  end

  // Set wins over acknowledge; a live condition keeps its request
  assign condAll = {condLevel[8:7], blockXferRequest, instrRoomFlag, condLevel[4:0]};
  assign ackClr  = (regWr && idx == `GHP_IDX_IACK) ? wrWord[8:0] : '0;
  assign pickAck = regWr && idx == `GHP_IDX_IACK && wrWord[`GHP_ACK_PICK];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      latch_r <= '0;
      pick_r  <= 1'b0;
    end else begin
      latch_r <= (latch_r & ~(ackClr & ~condAll)) | condAll;
      pick_r  <= (pick_r && !pickAck) || (pickHit && pickEnable);
    end
  end

  // Status is built from flops and the live idle input, so reading it disturbs nothing
  assign statusWord = {blockXferRequest, instrRoomFlag, pick_r, 1'b0, hs_r, condLevel[0],
                       latch_r, |(latch_r & ien_r)};

  // Acknowledge and reset registers read as zero; control and enable read their live registers; others read back their store
  always_comb begin
    unique case (idx)
      `GHP_IDX_IACK, `GHP_IDX_RESET: regWord = '0;
      `GHP_IDX_CTRL: regWord = {12'h000, ctrl};
      `GHP_IDX_IEN:  regWord = {7'h00, ien_r};
      default:       regWord = regMem[idx];
    endcase
    if (byteMode) begin
      regWord = {8'h00, (phase_r ^ byteOrder_r) ? regWord[7:0] : regWord[15:8]};
    end
  end

  always_comb begin
    unique case (bus_r.sel)
      GHP_SEL_QUEUE: readWord = statusWord;
      GHP_SEL_BLOCK: readWord = boHead;
      GHP_SEL_INDEX: readWord = index_r;
      GHP_SEL_DATA:  readWord = regWord;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hostDataOut <= '0;
      hostDataOe  <= 1'b0;
    end else begin
      hostDataOe <= bus_r.rd;
      if (rdEdge) begin
        hostDataOut <= readWord;
      end
    end
  end

  full_drop_a: assert property (@(posedge clk) disable iff (reset)
    wrEdge && bus_r.sel == GHP_SEL_QUEUE && iCount == 4'(`GHP_IFIFO_DEPTH) && !instrPop && !coreReset
    |=> iCount == 4'(`GHP_IFIFO_DEPTH)) else $error("full instruction queue grew");
  room_flag_a: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> instrRoomFlag == ($past(iCount) != 4'(`GHP_IFIFO_DEPTH))) else $error("room flag wrong");
  no_flush_a: assert property (@(posedge clk) disable iff (reset)
    !coreReset |=> iCount + 4'h1 >= $past(iCount)) else $error("queue flushed without reset");
  block_req_a: assert property (@(posedge clk) disable iff (reset)
    blockXferRequest && !$past(blockOutActive) |-> $past(biCount) <= 3'h2) else $error("block request early");
  soft_reset_a: assert property (@(posedge clk) disable iff (reset)
    coreReset |=> iCount == '0 && !byteMode && ctrl.videoTiming == $past(ctrl.videoTiming))
    else $error("soft reset wrong");
  index_read_a: assert property (@(posedge clk) disable iff (reset)
    rdEdge && bus_r.sel == GHP_SEL_INDEX |=> hostDataOut == $past(index_r)) else $error("index read wrong");
  ack_keep_a: assert property (@(posedge clk) disable iff (reset)
    latch_r[0] && condAll[0] |=> latch_r[0]) else $error("live request cleared");
  pick_clear_a: assert property (@(posedge clk) disable iff (reset)
    pick_r && !pickAck |=> pick_r) else $error("pick flag lost");
  status_mirror_a: assert property (@(posedge clk) disable iff (reset)
    rdEdge && bus_r.sel == GHP_SEL_QUEUE |=> hostDataOut[15:14] == $past({blockXferRequest, instrRoomFlag}))
    else $error("status flow bits wrong");
endmodule // ghp_host_port

// [tb/ghp_host_model.sv]
// Host bus master model for the graphics host port
`timescale 1ns/1ns
module ghp_host_model (
  // Clock
  input  wire logic        clk,
  // Host pins
  output logic             portSelHi,
  output logic             portSelLo,
  output logic             rdStrobe,
  output logic             wrStrobe,
  output logic [15:0]      hostDataIn,
  input  wire logic [15:0] hostDataOut,
  input  wire logic        hostDataOe,
  // Status
  output logic             timedOut
);
  initial begin
    {portSelHi, portSelLo, rdStrobe, wrStrobe} = 4'h0;
    hostDataIn = 16'h0000;
    timedOut = 1'b0;
  end
  // Select and data settle 3 clocks ahead; write strobes span 4 clocks each way, read strobes stay 4 clocks past output enable
  task automatic access(input logic rd, input logic [1:0] sel, input logic [15:0] d, output logic [15:0] q);
    int n;
    @(negedge clk);
    {portSelHi, portSelLo} = sel;
    hostDataIn = d;
    repeat (3) @(negedge clk);
    if (rd) rdStrobe = 1'b1;
    else wrStrobe = 1'b1;
    n = 0;
    while (rd && hostDataOe !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    if (n == 12) timedOut = 1'b1;
    repeat (4) @(negedge clk);
    q = hostDataOut;
    rdStrobe = 1'b0;
    wrStrobe = 1'b0;
    // Released bus shows junk, never the last word
    hostDataIn = ~d;
    repeat (4) @(negedge clk);
  endtask
endmodule // ghp_host_model

// [tb/tb_ghp_host_port.sv]
// Self-checking bench for the graphics host port
`timescale 1ns/1ns
module tb_ghp_host_port;
  import ghp_pkg::*;
  logic         clk, reset, portSelHi, portSelLo, rdStrobe, wrStrobe, hostDataOe, timedOut;
  logic         instrRoomFlag, blockXferRequest, instrPop, instrValid, blockInActive, blockInPop;
  logic         blockInValid, blockOutActive, blockOutPush, blockOutRoom, pickHit, pickEnable;
  logic         horizSyncResetPin, regWrStrobe, coreReset, byteMode;
  logic [15:0]  hostDataIn, hostDataOut, instrWord, blockInWord, blockOutData, regWrData, q;
  logic [8:0]   condLevel;
  logic [5:0]   regWrIndex;
  ghp_ctrl_type ctrl;
  int           nErrors, nChecks, nRegWr;

  ghp_host_port u_dut (
    .clk(clk), .reset(reset), .portSelHi(portSelHi), .portSelLo(portSelLo), .rdStrobe(rdStrobe),
    .wrStrobe(wrStrobe), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
    .instrRoomFlag(instrRoomFlag), .blockXferRequest(blockXferRequest), .instrPop(instrPop),
    .instrWord(instrWord), .instrValid(instrValid), .blockInActive(blockInActive), .blockInPop(blockInPop),
    .blockInWord(blockInWord), .blockInValid(blockInValid), .blockOutActive(blockOutActive),
    .blockOutPush(blockOutPush), .blockOutData(blockOutData), .blockOutRoom(blockOutRoom),
    .condLevel(condLevel), .pickHit(pickHit), .pickEnable(pickEnable),
    .horizSyncResetPin(horizSyncResetPin), .regWrStrobe(regWrStrobe), .regWrIndex(regWrIndex),
    .regWrData(regWrData), .ctrl(ctrl), .coreReset(coreReset), .byteMode(byteMode)
  );
  ghp_host_model u_host (
    .clk(clk), .portSelHi(portSelHi), .portSelLo(portSelLo), .rdStrobe(rdStrobe), .wrStrobe(wrStrobe),
    .hostDataIn(hostDataIn), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .timedOut(timedOut)
  );

  always #5 clk = ~clk;

  // Counts committed register writes seen by the engine
  always @(posedge clk) begin
    if (reset) begin
      nRegWr <= 0;
    end else if (regWrStrobe === 1'b1) begin
      nRegWr <= nRegWr + 1;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] sel, input logic [15:0] d);
    logic [15:0] r;
    u_host.access(1'b0, sel, d, r);
  endtask
  task automatic rd(input logic [1:0] sel);
    u_host.access(1'b1, sel, 16'h0000, q);
  endtask
  task automatic regWr(input logic [15:0] idx, input logic [15:0] d);
    wr(2'b10, idx);
    wr(2'b11, d);
  endtask
  // Gap before raising keeps two pops from sharing one time step
  task automatic pop(input logic blk, input logic v, input logic [15:0] exp);
    @(negedge clk);
    if (blk) blockInPop = 1'b1;
    else instrPop = 1'b1;
    @(negedge clk);
    blockInPop = 1'b0;
    instrPop = 1'b0;
    check(16'(blk ? blockInValid : instrValid), 16'(v));
    if (v) check(blk ? blockInWord : instrWord, exp);
  endtask
  task automatic pulsePick();
    @(negedge clk);
    pickHit = 1'b1;
    @(negedge clk);
    pickHit = 1'b0;
  endtask
  task automatic finishTest();
    $display("checks %0d mismatches %0d", nChecks, nErrors);
    if (nErrors == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // About 1100 clocks of traffic expected
  initial begin
    #100us;
    nErrors++;
    finishTest();
  end

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    {instrPop, blockInActive, blockInPop, blockOutActive, blockOutPush} = 5'h00;
    {pickHit, pickEnable, horizSyncResetPin} = 3'h0;
    condLevel = 9'h000;
    blockOutData = 16'h0000;
    nErrors = 0;
    nChecks = 0;
    repeat (4) @(negedge clk);
    check(16'(coreReset), 16'h0001);
    reset = 1'b0;
    rd(2'b00);
    check(q & 16'hc000, 16'h4000);
    check({11'h000, byteMode, ctrl}, 16'h0000);
    regWr(16'h0012, 16'h0005);
    check({10'h000, regWrIndex}, 16'h0012);
    check(regWrData, 16'h0005);
    check(16'(nRegWr), 16'h0001);
    check({12'h000, ctrl}, 16'h0005);
    rd(2'b10);
    check(q, 16'h0012);
    rd(2'b11);
    check(q, 16'h0005);
    regWr(16'h0011, 16'h01ff);
    rd(2'b11);
    check(q, 16'h0000);
    $display("test registers done");
    condLevel = 9'h002;
    rd(2'b00);
    check(q & 16'h0005, 16'h0004);
    regWr(16'h0010, 16'h0002);
    rd(2'b00);
    check(q & 16'h0005, 16'h0005);
    regWr(16'h0011, 16'h0002);
    rd(2'b00);
    check(q & 16'h0005, 16'h0005);
    condLevel = 9'h000;
    wr(2'b11, 16'h0002);
    rd(2'b00);
    check(q & 16'h0005, 16'h0000);
    condLevel = 9'h001;
    rd(2'b00);
    check(q & 16'h0402, 16'h0402);
    condLevel = 9'h000;
    rd(2'b00);
    check(q & 16'h0402, 16'h0002);
    for (int i = 2; i < 9; i++) begin
      condLevel = 9'h001 << i;
      rd(2'b00);
      if (i != 5 && i != 6) check(q & (16'h0002 << i), 16'h0002 << i);
    end
    condLevel = 9'h000;
    wr(2'b11, 16'h01ff);
    rd(2'b00);
    check(q & 16'h033e, 16'h0000);
    horizSyncResetPin = 1'b1;
    rd(2'b00);
    check(q & 16'h0800, 16'h0800);
    horizSyncResetPin = 1'b0;
    pulsePick();
    rd(2'b00);
    check(q & 16'h2800, 16'h0000);
    pickEnable = 1'b1;
    pulsePick();
    wr(2'b11, 16'h01ff);
    rd(2'b00);
    check(q & 16'h2000, 16'h2000);
    wr(2'b11, 16'h0200);
    rd(2'b00);
    check(q & 16'h2000, 16'h0000);
    $display("test status done");
    regWr(16'h0012, 16'h000f);
    wr(2'b00, 16'h1234);
    regWr(16'h001b, 16'h0000);
    check({12'h000, ctrl}, 16'h0001);
    pop(1'b0, 1'b0, 16'h0000);
    repeat (100) @(negedge clk);
    for (int i = 0; i < 9; i++) begin
      wr(2'b00, 16'ha000 + 16'(i));
      if (i == 3) rd(2'b00);
    end
    check(16'(instrRoomFlag), 16'h0000);
    rd(2'b00);
    check(q & 16'h4000, 16'h0000);
    for (int i = 0; i < 8; i++) pop(1'b0, 1'b1, 16'ha000 + 16'(i));
    pop(1'b0, 1'b0, 16'h0000);
    check(16'(instrRoomFlag), 16'h0001);
    $display("test instruction queue done");
    blockInActive = 1'b1;
    repeat (2) @(negedge clk);
    check(16'(blockXferRequest), 16'h0001);
    for (int i = 0; i < 5; i++) begin
      wr(2'b01, 16'hb000 + 16'(i));
      check(16'(blockXferRequest), 16'(i < 2));
    end
    for (int i = 0; i < 4; i++) pop(1'b1, 1'b1, 16'hb000 + 16'(i));
    pop(1'b1, 1'b0, 16'h0000);
    blockInActive = 1'b0;
    blockOutActive = 1'b1;
    for (int i = 0; i < 5; i++) begin
      blockOutData = 16'hc000 + 16'(i);
      blockOutPush = 1'b1;
      @(negedge clk);
      blockOutPush = 1'b0;
      @(negedge clk);
      check(16'(blockXferRequest), 16'(i > 0));
    end
    check(16'(blockOutRoom), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      rd(2'b01);
      check(q, 16'hc000 + 16'(i));
    end
    check(16'(blockOutRoom), 16'h0001);
    blockOutActive = 1'b0;
    $display("test block queues done");
    regWr(16'h0013, 16'h0000);
    check(16'(byteMode), 16'h0001);
    wr(2'b10, 16'h0012);
    wr(2'b11, 16'hab00);
    check({12'h000, ctrl}, 16'h0001);
    wr(2'b11, 16'hcd06);
    check({12'h000, ctrl}, 16'h0006);
    rd(2'b11);
    check(q, 16'h0000);
    rd(2'b11);
    check(q, 16'h0006);
    // Low byte first from here on
    wr(2'b10, 16'h0014);
    wr(2'b11, 16'h0000);
    wr(2'b11, 16'h0001);
    wr(2'b10, 16'h0012);
    wr(2'b11, 16'h0009);
    wr(2'b11, 16'h0000);
    check({12'h000, ctrl}, 16'h0009);
    rd(2'b11);
    check(q, 16'h0009);
    rd(2'b11);
    check(q, 16'h0000);
    reset = 1'b1;
    @(negedge clk);
    check(16'(coreReset), 16'h0001);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    check({11'h000, byteMode, ctrl}, 16'h0000);
    check(16'(instrRoomFlag), 16'h0001);
    check(16'(timedOut), 16'h0000);
    $display("test byte mode done");
    finishTest();
  end
endmodule // tb_ghp_host_port
